// [rtl/ppo_port.sv]
// port pin override control: wishbone registers, pins and interrupt flags
//
// Operation
// - sleep clamps each digital input to ground
// - enabled external interrupt pin escapes sleep clamp
// - clamp release on wake sets a rising or any-change interrupt flag
// - inputs enabled in reset, active and idle
// - software pull-up forced off during reset
// - pull-up from override, else dir/out/pud 010
// - driver enable from override or dir bit
// - driven value from override or out bit
// - toggle override inverts the out bit
// - input enable override bypasses sleep state
// - alt digital input taken before synchroniser
// - analog path wired straight to the pad
// - strobes per port, sleep/pud/clock shared
// - dir one is output, zero input
// - writing one to pin bit toggles out
// - pin read passes through two-stage synchroniser
// - pins tri-stated at once under reset
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module ppo_port
    import ppo_pkg::*;
#(
    parameter int N_PINS = 8
)
(
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    // wishbone classic slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // shared system controls
    input wire logic I_SLEEP,
    // per-pin overrides from peripherals
    input wire logic [N_PINS-1:0] I_PULLUP_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_PULLUP_OVERRIDE_VAL,
    input wire logic [N_PINS-1:0] I_DIR_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_DIR_OVERRIDE_VAL,
    input wire logic [N_PINS-1:0] I_VALUE_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_VALUE_OVERRIDE_VAL,
    input wire logic [N_PINS-1:0] I_TOGGLE_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_INPUT_EN_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_INPUT_EN_OVERRIDE_VAL,
    // pads
    input wire logic [N_PINS-1:0] I_PAD_IN,
    output logic [N_PINS-1:0] O_PAD_OUT,
    output logic [N_PINS-1:0] O_PAD_OE,
    output logic [N_PINS-1:0] O_PULLUP_EN,
    // toward peripherals
    output logic [N_PINS-1:0] O_ALT_DIGITAL_IN,
    output logic [N_PINS-1:0] O_ALT_ANALOG_IO,
    output logic [N_PINS-1:0] O_EXT_INT_FLAG
);

    // ==========================================================
    // declarations
    logic [N_PINS-1:0] dir_r;
    logic [N_PINS-1:0] dir_nxt;
    logic [N_PINS-1:0] out_r;
    logic [N_PINS-1:0] out_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [N_PINS-1:0] ext_en_r;
    logic [N_PINS-1:0] ext_en_nxt;
    logic [2*N_PINS-1:0] sense_r;
    logic [2*N_PINS-1:0] sense_nxt;
    logic [N_PINS-1:0] flag_r;
    logic [N_PINS-1:0] flag_nxt;
    logic [N_PINS-1:0] prev_r;
    logic [N_PINS-1:0] prev_nxt;
    logic [N_PINS-1:0] pin_sync;
    logic [N_PINS-1:0] event_hit;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic req;
    logic wr_dir;
    logic wr_out;
    logic wr_pin;
    logic wr_ctrl;
    logic wr_ext_en;
    logic wr_sense;
    logic wr_flag;
    logic pullup_global_disable;

    // ==========================================================
    // bus request decode
    // one new access per request; ack_r blocks a second strobe cycle
    always_comb
    begin
        // reads load on the taking edge, ack rises on that same edge
        req = I_WB_CYC & I_WB_STB & ~ack_r;
        for (int b = 0; b < 4; b++)
        begin
            wmask[8*b +: 8] = {8{I_WB_SEL[b]}};
        end
        wdat = I_WB_DAT & wmask;
        wr_dir = 1'b0;
        wr_out = 1'b0;
        wr_pin = 1'b0;
        wr_ctrl = 1'b0;
        wr_ext_en = 1'b0;
        wr_sense = 1'b0;
        wr_flag = 1'b0;
        // strobes are common to every pin; writes land on the edge the master sees ack
        if (I_WB_CYC && I_WB_STB && I_WB_WE && ack_r)
        begin
            if (I_WB_ADR == PPO_OFS_DIR)
                wr_dir = 1'b1;
            else if (I_WB_ADR == PPO_OFS_OUT)
                wr_out = 1'b1;
            else if (I_WB_ADR == PPO_OFS_PIN)
                wr_pin = 1'b1;
            else if (I_WB_ADR == PPO_OFS_CTRL)
                wr_ctrl = 1'b1;
            else if (I_WB_ADR == PPO_OFS_EXT_EN)
                wr_ext_en = 1'b1;
            else if (I_WB_ADR == PPO_OFS_EXT_SENSE)
                wr_sense = 1'b1;
            else if (I_WB_ADR == PPO_OFS_EXT_FLAG)
                wr_flag = 1'b1;
        end
    end

    // ==========================================================
    // configuration registers
    // byte-lane masked writes; pin writes and toggle override flip out bits
    always_comb
    begin
        dir_nxt = dir_r;
        out_nxt = out_r;
        ctrl_nxt = ctrl_r;
        ext_en_nxt = ext_en_r;
        sense_nxt = sense_r;
        if (wr_dir)
            dir_nxt = (dir_r & ~wmask[N_PINS-1:0]) | wdat[N_PINS-1:0];
        if (wr_out)
            out_nxt = (out_r & ~wmask[N_PINS-1:0]) | wdat[N_PINS-1:0];
        if (wr_pin)
            out_nxt = out_nxt ^ wdat[N_PINS-1:0];
        out_nxt = out_nxt ^ I_TOGGLE_OVERRIDE_EN;
        if (wr_ctrl)
        begin
            // only the pull-up disable bit is writable
            ctrl_nxt[PPO_CTRL_PUD_BIT] = wmask[PPO_CTRL_PUD_BIT]
                ? I_WB_DAT[PPO_CTRL_PUD_BIT] : ctrl_r[PPO_CTRL_PUD_BIT];
        end
        if (wr_ext_en)
            ext_en_nxt = (ext_en_r & ~wmask[N_PINS-1:0]) | wdat[N_PINS-1:0];
        if (wr_sense)
            sense_nxt = (sense_r & ~wmask[2*N_PINS-1:0]) | wdat[2*N_PINS-1:0];
        pullup_global_disable = ctrl_r[PPO_CTRL_PUD_BIT];
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            dir_r <= PPO_RST_DIR[N_PINS-1:0];
            out_r <= PPO_RST_OUT[N_PINS-1:0];
            ctrl_r <= PPO_RST_CTRL;
            ext_en_r <= PPO_RST_EXT_EN[N_PINS-1:0];
            sense_r <= PPO_RST_EXT_SENSE[2*N_PINS-1:0];
        end
        else
        begin
            dir_r <= dir_nxt;
            out_r <= out_nxt;
            ctrl_r <= ctrl_nxt;
            ext_en_r <= ext_en_nxt;
            sense_r <= sense_nxt;
        end
    end

    // ==========================================================
    // pin instances
    // each pin owns its overrides; sleep, pud and clock are shared
    generate
        for (genvar p = 0; p < N_PINS; p++)
        begin : g_pin
            ppo_pin u_pin
            (
                .i_clk(I_REF_CLK),
                .i_nrst(I_NRST),
                .i_dir(dir_r[p]),
                .i_out(out_r[p]),
                .i_pud(pullup_global_disable),
                .i_sleep(I_SLEEP),
                .i_ext_en(ext_en_r[p]),
                .i_pu_oe(I_PULLUP_OVERRIDE_EN[p]),
                .i_pu_ov(I_PULLUP_OVERRIDE_VAL[p]),
                .i_dd_oe(I_DIR_OVERRIDE_EN[p]),
                .i_dd_ov(I_DIR_OVERRIDE_VAL[p]),
                .i_pv_oe(I_VALUE_OVERRIDE_EN[p]),
                .i_pv_ov(I_VALUE_OVERRIDE_VAL[p]),
                .i_die_oe(I_INPUT_EN_OVERRIDE_EN[p]),
                .i_die_ov(I_INPUT_EN_OVERRIDE_VAL[p]),
                .i_pad_in(I_PAD_IN[p]),
                .o_pad_out(O_PAD_OUT[p]),
                .o_pad_oe(O_PAD_OE[p]),
                .o_pullup(O_PULLUP_EN[p]),
                .o_alt_din(O_ALT_DIGITAL_IN[p]),
                .o_pin_sync(pin_sync[p])
            );
        end
    endgenerate

    // analog path taps the raw pad, ahead of any clamp or gating
    always_comb
    begin
        O_ALT_ANALOG_IO = I_PAD_IN;
    end

    // ==========================================================
    // external interrupt flags
    // edges and low levels on the synchronised, clamp-gated input; a clamp released
    // on wake-up reads as a rising edge and sets a rising or any-change flag
    always_comb
    begin
        prev_nxt = pin_sync;
        for (int i = 0; i < N_PINS; i++)
        begin
            case (ppo_sense_e'(sense_r[2*i +: 2]))
                PPO_SENSE_LOW:
                    event_hit[i] = ~pin_sync[i];
                PPO_SENSE_ANY:
                    event_hit[i] = pin_sync[i] ^ prev_r[i];
                PPO_SENSE_FALL:
                    event_hit[i] = prev_r[i] & ~pin_sync[i];
                PPO_SENSE_RISE:
                    event_hit[i] = ~prev_r[i] & pin_sync[i];
                default:
                    event_hit[i] = 1'b0;
            endcase
        end
        // write one clears; a same-cycle event wins over the clear
        flag_nxt = flag_r;
        if (wr_flag)
            flag_nxt = flag_r & ~wdat[N_PINS-1:0];
        flag_nxt = flag_nxt | event_hit;
        O_EXT_INT_FLAG = flag_r;
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            prev_r <= '0;
            flag_r <= '0;
        end
        else
        begin
            prev_r <= prev_nxt;
            flag_r <= flag_nxt;
        end
    end

    // ==========================================================
    // bus answer
    // registered ack one cycle after the strobe; unmapped reads zero
    always_comb
    begin
        ack_nxt = req;
        rdat_nxt = rdat_r;
        if (req && !I_WB_WE)
        begin
            rdat_nxt = PPO_RD_UNMAPPED;
            if (I_WB_ADR == PPO_OFS_DIR)
                rdat_nxt[N_PINS-1:0] = dir_r;
            else if (I_WB_ADR == PPO_OFS_OUT)
                rdat_nxt[N_PINS-1:0] = out_r;
            else if (I_WB_ADR == PPO_OFS_PIN)
                rdat_nxt[N_PINS-1:0] = pin_sync;
            else if (I_WB_ADR == PPO_OFS_CTRL)
                rdat_nxt[7:0] = ctrl_r;
            else if (I_WB_ADR == PPO_OFS_EXT_EN)
                rdat_nxt[N_PINS-1:0] = ext_en_r;
            else if (I_WB_ADR == PPO_OFS_EXT_SENSE)
                rdat_nxt[2*N_PINS-1:0] = sense_r;
            else if (I_WB_ADR == PPO_OFS_EXT_FLAG)
                rdat_nxt[N_PINS-1:0] = flag_r;
        end
        O_WB_ACK = ack_r;
        O_WB_DAT = rdat_r;
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            ack_r <= 1'b0;
            rdat_r <= PPO_RD_UNMAPPED;
        end
        else
        begin
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

endmodule

// [rtl/ppo_pkg.sv]
// constants shared by the port pin override control block
package ppo_pkg;

    // ==========================================================
    // register byte offsets on the wishbone slave
    localparam logic [7:0] PPO_OFS_DIR = 8'h00;
    localparam logic [7:0] PPO_OFS_OUT = 8'h04;
    localparam logic [7:0] PPO_OFS_PIN = 8'h08;
    localparam logic [7:0] PPO_OFS_CTRL = 8'h0C;
    localparam logic [7:0] PPO_OFS_EXT_EN = 8'h10;
    localparam logic [7:0] PPO_OFS_EXT_SENSE = 8'h14;
    localparam logic [7:0] PPO_OFS_EXT_FLAG = 8'h18;

    // ==========================================================
    // field positions and reset values
    localparam int PPO_CTRL_PUD_BIT = 4;
    localparam logic [7:0] PPO_RST_DIR = 8'h00;
    localparam logic [7:0] PPO_RST_OUT = 8'h00;
    localparam logic [7:0] PPO_RST_CTRL = 8'h00;
    localparam logic [7:0] PPO_RST_EXT_EN = 8'h00;
    localparam logic [15:0] PPO_RST_EXT_SENSE = 16'h0000;
    localparam logic [31:0] PPO_RD_UNMAPPED = 32'h0000_0000;

    // ==========================================================
    // external interrupt sense codes, two bits per pin
    typedef enum logic [1:0]
    {
        PPO_SENSE_LOW,
        PPO_SENSE_ANY,
        PPO_SENSE_FALL,
        PPO_SENSE_RISE
    } ppo_sense_e;

endpackage

// [rtl/ppo_pin.sv]
// one port pin: override muxing, sleep clamp, pad drive and input synchroniser
`timescale 1ns/1ps
module ppo_pin
    import ppo_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // register bits and shared controls
    input wire logic i_dir,
    input wire logic i_out,
    input wire logic i_pud,
    input wire logic i_sleep,
    input wire logic i_ext_en,
    // overrides from the owning peripheral
    input wire logic i_pu_oe,
    input wire logic i_pu_ov,
    input wire logic i_dd_oe,
    input wire logic i_dd_ov,
    input wire logic i_pv_oe,
    input wire logic i_pv_ov,
    input wire logic i_die_oe,
    input wire logic i_die_ov,
    // pad side
    input wire logic i_pad_in,
    output logic o_pad_out,
    output logic o_pad_oe,
    output logic o_pullup,
    // toward peripherals and the pin register
    output logic o_alt_din,
    output logic o_pin_sync
);

    logic drv_en;
    logic in_en;
    logic sync1_r;
    logic sync1_nxt;
    logic sync2_r;
    logic sync2_nxt;

    // ==========================================================
    // output path
    // driver enable from override or direction bit
    always_comb
    begin
        drv_en = i_dd_oe ? i_dd_ov : i_dir;
        o_pad_oe = drv_en & i_nrst;
        o_pad_out = drv_en & (i_pv_oe ? i_pv_ov : i_out);
    end

    // pull-up from override or {dir,out,pud} == 010, never in reset
    always_comb
    begin
        if (!i_nrst)
            o_pullup = 1'b0;
        else if (i_pu_oe)
            o_pullup = i_pu_ov;
        else
            o_pullup = ({i_dir, i_out, i_pud} == 3'b010);
    end

    // ==========================================================
    // input path
    // input enable: forced on in reset, override, else sleep clamp
    always_comb
    begin
        if (!i_nrst)
            in_en = 1'b1;
        else if (i_die_oe)
            in_en = i_die_ov;
        else
            in_en = ~i_sleep | i_ext_en;
        o_alt_din = i_pad_in & in_en;
    end

    // two stage synchroniser feeding the pin register read
    always_comb
    begin
        sync1_nxt = o_alt_din;
        sync2_nxt = sync1_r;
        o_pin_sync = sync2_r;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

endmodule

// [tb/ppo_port_assertions.sv]
// concurrent checks on the ports of the port pin override control block
`timescale 1ns/1ps
module ppo_port_assertions
    import ppo_pkg::*;
#(
    parameter int N_PINS = 8
)
(
    // clock, reset and bus
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic O_WB_ACK,
    // controls and overrides
    input wire logic I_SLEEP,
    input wire logic [N_PINS-1:0] I_PULLUP_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_PULLUP_OVERRIDE_VAL,
    input wire logic [N_PINS-1:0] I_DIR_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_DIR_OVERRIDE_VAL,
    input wire logic [N_PINS-1:0] I_VALUE_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_VALUE_OVERRIDE_VAL,
    input wire logic [N_PINS-1:0] I_INPUT_EN_OVERRIDE_EN,
    input wire logic [N_PINS-1:0] I_INPUT_EN_OVERRIDE_VAL,
    // pads and flags
    input wire logic [N_PINS-1:0] I_PAD_IN,
    input wire logic [N_PINS-1:0] O_PAD_OUT,
    input wire logic [N_PINS-1:0] O_PAD_OE,
    input wire logic [N_PINS-1:0] O_PULLUP_EN,
    input wire logic [N_PINS-1:0] O_ALT_DIGITAL_IN,
    input wire logic [N_PINS-1:0] O_ALT_ANALOG_IO,
    input wire logic [N_PINS-1:0] O_EXT_INT_FLAG
);
    // ==========================================
    // common clocking and bus sequences
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_NRST);
    sequence wb_req;
        I_WB_CYC && I_WB_STB && !O_WB_ACK;
    endsequence
    sequence ack_pulse;
        O_WB_ACK ##1 !O_WB_ACK;
    endsequence
    // ==========================================
    // assertions
    wb_answer_a: assert property (wb_req |=> ack_pulse)
        else $error("bus request not answered by one ack");
    oe_override_a: assert property (
        (O_PAD_OE & I_DIR_OVERRIDE_EN) == (I_DIR_OVERRIDE_VAL & I_DIR_OVERRIDE_EN))
        else $error("driver enable ignores override");
    val_override_a: assert property (
        (O_PAD_OUT & O_PAD_OE & I_VALUE_OVERRIDE_EN)
        == (I_VALUE_OVERRIDE_VAL & O_PAD_OE & I_VALUE_OVERRIDE_EN))
        else $error("driven value ignores override");
    pu_override_a: assert property (
        (O_PULLUP_EN & I_PULLUP_OVERRIDE_EN) == (I_PULLUP_OVERRIDE_VAL & I_PULLUP_OVERRIDE_EN))
        else $error("pull-up ignores override");
    pu_output_a: assert property (
        (O_PULLUP_EN & O_PAD_OE & ~I_PULLUP_OVERRIDE_EN & ~I_DIR_OVERRIDE_EN) == '0)
        else $error("pull-up on a driven pin");
    ie_override_a: assert property (
        (O_ALT_DIGITAL_IN & I_INPUT_EN_OVERRIDE_EN)
        == (I_PAD_IN & I_INPUT_EN_OVERRIDE_VAL & I_INPUT_EN_OVERRIDE_EN))
        else $error("input enable ignores override");
    awake_input_a: assert property (!I_SLEEP |->
        (O_ALT_DIGITAL_IN & ~I_INPUT_EN_OVERRIDE_EN) == (I_PAD_IN & ~I_INPUT_EN_OVERRIDE_EN))
        else $error("input gated while awake");
    analog_path_a: assert property (O_ALT_ANALOG_IO == I_PAD_IN)
        else $error("analog path not the pad");
    flag_sticky_a: assert property (
        |($past(O_EXT_INT_FLAG) & ~O_EXT_INT_FLAG) |->
        $past(I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_ADR == PPO_OFS_EXT_FLAG))
        else $error("flag cleared without a write");
    reset_quiet_a: assert property (@(posedge I_REF_CLK) disable iff (1'b0)
        !I_NRST |-> O_PAD_OE == '0 && O_PULLUP_EN == '0 && O_WB_ACK == 1'b0)
        else $error("pins active in reset");
endmodule

// [tb/ppo_periph_model.sv]
// behavioural peripheral that drives the override signals of all pins
`timescale 1ns/1ps
module ppo_periph_model
(
    // clock and command
    input wire logic i_clk,
    input wire logic [2:0] i_mode,
    input wire logic [7:0] i_val,
    // override outputs
    output logic [7:0] o_pu_oe = 8'h00,
    output logic [7:0] o_pu_ov = 8'h00,
    output logic [7:0] o_dd_oe = 8'h00,
    output logic [7:0] o_dd_ov = 8'h00,
    output logic [7:0] o_pv_oe = 8'h00,
    output logic [7:0] o_pv_ov = 8'h00,
    output logic [7:0] o_pt_oe = 8'h00,
    output logic [7:0] o_ie_oe = 8'h00,
    output logic [7:0] o_ie_ov = 8'h00
);
    // modes 1, 2, 4 and 5 each claim one override kind, mode 3 direction and value; launched just after the edge
    always @(posedge i_clk)
    begin
        o_pu_oe <= {8{i_mode == 3'h1}};
        o_pu_ov <= i_val;
        o_dd_oe <= {8{i_mode == 3'h2 || i_mode == 3'h3}};
        o_dd_ov <= (i_mode == 3'h3) ? 8'hFF : i_val;
        o_pv_oe <= {8{i_mode == 3'h3}};
        o_pv_ov <= i_val;
        o_pt_oe <= (i_mode == 3'h4) ? i_val : 8'h00;
        o_ie_oe <= {8{i_mode == 3'h5}};
        o_ie_ov <= i_val;
    end
endmodule

// [tb/ppo_port_tb.sv]
// self-checking testbench for the port pin override control block
`timescale 1ns/1ps
module ppo_port_tb;
    import ppo_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic I_REF_CLK = 1'b0;
    logic I_NRST = 1'b1;
    logic I_WB_CYC = 1'b0, I_WB_STB = 1'b0, I_WB_WE = 1'b0, I_SLEEP = 1'b1, O_WB_ACK;
    logic [7:0] I_WB_ADR = 8'h00, I_PAD_IN = 8'h3C, mval = 8'h00;
    logic [3:0] I_WB_SEL = 4'h0;
    logic [31:0] I_WB_DAT = 32'h0, O_WB_DAT, q;
    logic [2:0] mode = 3'h0;
    logic [7:0] I_PULLUP_OVERRIDE_EN, I_PULLUP_OVERRIDE_VAL, I_DIR_OVERRIDE_EN;
    logic [7:0] I_DIR_OVERRIDE_VAL, I_VALUE_OVERRIDE_EN, I_VALUE_OVERRIDE_VAL;
    logic [7:0] I_TOGGLE_OVERRIDE_EN, I_INPUT_EN_OVERRIDE_EN, I_INPUT_EN_OVERRIDE_VAL;
    logic [7:0] O_PAD_OUT, O_PAD_OE, O_PULLUP_EN, O_ALT_DIGITAL_IN, O_ALT_ANALOG_IO;
    logic [7:0] O_EXT_INT_FLAG;
    int fail_count = 0;
    int n_compared = 0;
    // ==========================================
    // design, peripheral model and clock
    ppo_port #(.N_PINS(8)) i_dut (.*);
    ppo_periph_model i_peer (.i_clk(I_REF_CLK), .i_mode(mode), .i_val(mval),
        .o_pu_oe(I_PULLUP_OVERRIDE_EN), .o_pu_ov(I_PULLUP_OVERRIDE_VAL),
        .o_dd_oe(I_DIR_OVERRIDE_EN), .o_dd_ov(I_DIR_OVERRIDE_VAL),
        .o_pv_oe(I_VALUE_OVERRIDE_EN), .o_pv_ov(I_VALUE_OVERRIDE_VAL),
        .o_pt_oe(I_TOGGLE_OVERRIDE_EN), .o_ie_oe(I_INPUT_EN_OVERRIDE_EN),
        .o_ie_ov(I_INPUT_EN_OVERRIDE_VAL));
    initial
    begin
        forever #25 I_REF_CLK = ~I_REF_CLK;
    end
    // ==========================================
    // shared tasks
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask
    // classic wishbone cycle, held until ack is sampled, read data into q
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge I_REF_CLK);
        I_WB_CYC <= 1'b1;
        I_WB_STB <= 1'b1;
        I_WB_WE <= w;
        I_WB_ADR <= a;
        I_WB_DAT <= d;
        I_WB_SEL <= 4'hF;
        n = 0;
        do
        begin
            @(posedge I_REF_CLK);
            n++;
        end
        while (O_WB_ACK !== 1'b1 && n < 20);
        q = O_WB_DAT;
        I_WB_CYC <= 1'b0;
        I_WB_STB <= 1'b0;
        if (O_WB_ACK !== 1'b1)
        begin
            fail_count++;
            finish_test;
        end
    endtask
    // peripheral command, settled once the model and the pins follow
    task ovr(input logic [2:0] m, input logic [7:0] v);
        @(posedge I_REF_CLK);
        mode <= m;
        mval <= v;
        repeat (2) @(posedge I_REF_CLK);
        #1;
    endtask
    // ==========================================
    // scenarios
    task t_pins;
        wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h1C, 32'h0);
        check(q, PPO_RD_UNMAPPED);
        wb(1'b1, PPO_OFS_DIR, 32'h0F);
        wb(1'b1, PPO_OFS_OUT, 32'h3C);
        #1;
        check(32'(O_PAD_OE), 32'h0F);
        check(32'(O_PAD_OUT), 32'h0C);
        check(32'(O_PULLUP_EN), 32'h30);
        wb(1'b1, PPO_OFS_CTRL, 32'h10);
        #1;
        check(32'(O_PULLUP_EN), 32'h00);
        wb(1'b1, PPO_OFS_CTRL, 32'h00);
        @(posedge I_REF_CLK);
        I_NRST <= 1'b0;
        #10;
        check(32'(O_PAD_OE), 32'h00);
        check(32'(O_PULLUP_EN), 32'h00);
        @(posedge I_REF_CLK);
        I_NRST <= 1'b1;
        $display("pins and reset test done");
    endtask
    task t_ovr;
        wb(1'b1, PPO_OFS_OUT, 32'hFF);
        ovr(3'h1, 8'hA5);
        check(32'(O_PULLUP_EN), 32'hA5);
        ovr(3'h2, 8'h5A);
        check(32'(O_PAD_OE), 32'h5A);
        check(32'(O_PAD_OUT), 32'h5A);
        ovr(3'h3, 8'h96);
        check(32'(O_PAD_OUT), 32'h96);
        @(posedge I_REF_CLK);
        I_SLEEP <= 1'b1;
        I_PAD_IN <= 8'hFF;
        ovr(3'h5, 8'h0F);
        check(32'(O_ALT_DIGITAL_IN), 32'h0F);
        ovr(3'h0, 8'h00);
        $display("override test done");
    endtask
    task t_toggle;
        wb(1'b1, PPO_OFS_OUT, 32'h00);
        @(posedge I_REF_CLK);
        mode <= 3'h4;
        mval <= 8'h81;
        @(posedge I_REF_CLK);
        mode <= 3'h0;
        wb(1'b0, PPO_OFS_OUT, 32'h0);
        check(q, 32'h81);
        wb(1'b1, PPO_OFS_PIN, 32'h03);
        wb(1'b0, PPO_OFS_OUT, 32'h0);
        check(q, 32'h82);
        $display("toggle test done");
    endtask
    task t_input;
        wb(1'b1, PPO_OFS_EXT_EN, 32'h01);
        @(posedge I_REF_CLK);
        I_PAD_IN <= 8'hA5;
        #1;
        check(32'(O_ALT_DIGITAL_IN), 32'h01);
        check(32'(O_ALT_ANALOG_IO), 32'hA5);
        @(posedge I_REF_CLK);
        I_SLEEP <= 1'b0;
        I_PAD_IN <= 8'h5A;
        #1;
        check(32'(O_ALT_DIGITAL_IN), 32'h5A);
        repeat (3) @(posedge I_REF_CLK);
        wb(1'b0, PPO_OFS_PIN, 32'h0);
        check(q, 32'h5A);
        $display("input test done");
    endtask
    task t_wake;
        wb(1'b1, PPO_OFS_EXT_EN, 32'h00);
        // pin0 low level, pin1 falling, pin2 rising, pin3 any change
        wb(1'b1, PPO_OFS_EXT_SENSE, 32'h78);
        I_PAD_IN <= 8'hFF;
        repeat (4) @(posedge I_REF_CLK);
        wb(1'b1, PPO_OFS_EXT_FLAG, 32'hFF);
        I_SLEEP <= 1'b1;
        repeat (5) @(posedge I_REF_CLK);
        wb(1'b0, PPO_OFS_EXT_FLAG, 32'h0);
        check(q & 32'h0F, 32'h0B);
        // clear while asleep: the held low level sets pin0 again
        wb(1'b1, PPO_OFS_EXT_FLAG, 32'h0B);
        I_SLEEP <= 1'b0;
        repeat (5) @(posedge I_REF_CLK);
        wb(1'b0, PPO_OFS_EXT_FLAG, 32'h0);
        check(q & 32'h0F, 32'h0D);
        wb(1'b1, PPO_OFS_EXT_FLAG, 32'h04);
        wb(1'b0, PPO_OFS_EXT_FLAG, 32'h0);
        check(q & 32'h0F, 32'h09);
        check(32'(O_EXT_INT_FLAG) & 32'h0F, 32'h09);
        $display("wake flag test done");
    endtask
    // ==========================================
    // main sequence: sleep is requested during reset on purpose
    initial
    begin
        I_NRST <= 1'b0;
        repeat (7) @(posedge I_REF_CLK);
        #1;
        check(32'(O_PAD_OE), 32'h00);
        check(32'(O_PULLUP_EN), 32'h00);
        check(32'(O_ALT_DIGITAL_IN), 32'h3C);
        @(posedge I_REF_CLK);
        I_NRST <= 1'b1;
        I_SLEEP <= 1'b0;
        t_pins;
        t_ovr;
        t_toggle;
        t_input;
        t_wake;
        finish_test;
    end
endmodule
bind ppo_port ppo_port_assertions #(.N_PINS(N_PINS)) i_chk (.*);
